// ### pkg/hvm_consts.svh
// Constants for the high-voltage measurement switch control block.
// Assumes a 20 MHz hclk and an AHB-Lite register port with word access only.
`ifndef HVM_CONSTS_SVH
`define HVM_CONSTS_SVH
`define HVM_OFF_MEAS_CTRL 12'h000
`define HVM_OFF_PULL_CFG 12'h004
`define HVM_OFF_WAKE_CTRL1 12'h008
`define HVM_OFF_GPIN_CFG 12'h00c
`define HVM_OFF_MODE_CMD 12'h010
`define HVM_OFF_STATUS 12'h014
`define HVM_OFF_WAKE_STAT0 12'h018
`define HVM_OFF_WAKE_STAT1 12'h01c
`define HVM_OFF_WAKE_LVL 12'h020
`define HVM_OFF_ERR 12'h024
`define HVM_BIT_MEAS_EN 0
`define HVM_BIT_WAKE_EN 0
`define HVM_BIT_FO_TEST 4
`define HVM_GPIN_OFF 3'h0
`define HVM_GPIN_FO 3'h1
`define HVM_GPIN_WAKE 3'h2
`define HVM_RST_GPIN 3'h1
`define HVM_RST_PULL 2'h0
`define HVM_RST_WAKE1 8'h01
`endif

// ### pkg/hvm_pkg.sv
// Types shared by the measurement switch control logic.
// Assumes the companion constants header for offsets and reset values.
package hvm_pkg;
    typedef enum logic [2:0] {
        HVM_INIT = 3'b000,
        HVM_NORMAL = 3'b001,
        HVM_STOP = 3'b011,
        HVM_SLEEP = 3'b010,
        HVM_RESTART = 3'b110,
        HVM_FAILSAFE = 3'b111
    } hvm_mode_t;

    typedef struct packed {
        logic wake_in;
        logic gpin_in;
    } hvm_pins_t;

    typedef struct packed {
        logic [1:0] wake_pull;
        logic [1:0] gpin_pull;
        logic gpin_oe;
        logic gpin_out;
        logic meas_switch;
    } hvm_drive_t;
endpackage

// ### hdl/hvm_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are slow levels; no pulse stretching is done.
`timescale 1ns/10ps
module hvm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) $error("hvm_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ### hdl/hvm_ctrl.sv
// Measurement switch control: AHB-Lite registers, mode sequencing,
// pin gating and wake status capture for the wake input and general pin.
// Assumes a single AHB-Lite master issuing whole-word single transfers.
`timescale 1ns/10ps
`include "hvm_consts.svh"
module hvm_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire hvm_pkg::hvm_pins_t pins,
    output hvm_pkg::hvm_drive_t drive,
    output hvm_pkg::hvm_mode_t mode,
    output logic wake_event,
    output logic fail_out
);
    import hvm_pkg::*;

    hvm_pins_t pins_s;
    hvm_pins_t pins_prev_q;
    logic meas_en_q;
    logic [1:0] pull_q;
    logic [7:0] wake1_q;
    logic [2:0] gpin_q;
    logic [1:0] stat0_q;
    logic stat1_q;
    logic [1:0] lvl_q;
    logic err_q;
    logic fs_wake_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    hvm_mode_t mode_q;
    hvm_mode_t mode_d;
    logic [31:0] rdata_q;

    hvm_sync #(.WIDTH(2)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(pins),
        .q(pins_s)
    );

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // Address phase capture; this slave never stalls
    wire logic take = hsel && hready && htrans[1];
    wire logic rd_take = take && !hwrite;
    wire logic wr = wr_pend_q;
    wire logic wr_meas = wr && hit(wr_addr_q, `HVM_OFF_MEAS_CTRL);
    wire logic wr_pull = wr && hit(wr_addr_q, `HVM_OFF_PULL_CFG);
    wire logic wr_wake1 = wr && hit(wr_addr_q, `HVM_OFF_WAKE_CTRL1);
    wire logic wr_gpin = wr && hit(wr_addr_q, `HVM_OFF_GPIN_CFG);
    wire logic wr_mode = wr && hit(wr_addr_q, `HVM_OFF_MODE_CMD);
    wire logic wr_stat0 = wr && hit(wr_addr_q, `HVM_OFF_WAKE_STAT0);
    wire logic wr_stat1 = wr && hit(wr_addr_q, `HVM_OFF_WAKE_STAT1);
    wire logic wr_err = wr && hit(wr_addr_q, `HVM_OFF_ERR);

    // Enable only accepted while the general pin is off
    wire logic meas_set_req = wr_meas && hwdata[`HVM_BIT_MEAS_EN];
    wire logic meas_refuse = meas_set_req && !meas_en_q && (gpin_q != `HVM_GPIN_OFF);
    wire logic meas_d = wr_meas ? (hwdata[`HVM_BIT_MEAS_EN] && !meas_refuse) : meas_en_q;
    wire logic gpin_change = wr_gpin && meas_en_q && (hwdata[2:0] != gpin_q);

    // Wake sources: the pins are the only sources this block knows of
    wire logic wake_en_cfg = wake1_q[`HVM_BIT_WAKE_EN] || fs_wake_q;
    wire logic gpin_wake_cfg = (gpin_q == `HVM_GPIN_WAKE);
    wire logic pins_only_wake = wake_en_cfg || gpin_wake_cfg;
    wire logic sleep_cmd = wr_mode && (hwdata[2:0] == HVM_SLEEP);
    wire logic sleep_reject = sleep_cmd && meas_en_q && pins_only_wake;

    // Gated pin levels: while measuring, the pins feed no internal logic
    wire logic wake_live = !meas_en_q && pins_s.wake_in;
    wire logic gpin_live = !meas_en_q && pins_s.gpin_in;
    wire logic wake_edge = !meas_en_q && (pins_s.wake_in != pins_prev_q.wake_in);
    wire logic gpin_edge = !meas_en_q && (pins_s.gpin_in != pins_prev_q.gpin_in);
    wire logic wake_hit = wake_edge && wake_en_cfg;
    wire logic gpin_hit = gpin_edge && gpin_wake_cfg;

    always_comb begin
        mode_d = mode_q;
        if (sleep_reject) begin
            mode_d = HVM_RESTART;
        end else if (wr_mode) begin
            mode_d = hvm_mode_t'(hwdata[2:0]);
        end else if (mode_q == HVM_INIT || mode_q == HVM_RESTART) begin
            mode_d = HVM_NORMAL;
        end else if ((mode_q == HVM_SLEEP || mode_q == HVM_STOP) && (wake_hit || gpin_hit)) begin
            mode_d = HVM_RESTART;
        end
    end

    wire logic err_set = meas_refuse || gpin_change || sleep_reject;
    wire logic [31:0] rsel =
        hit(haddr, `HVM_OFF_MEAS_CTRL) ? {31'h0, meas_en_q} :
        hit(haddr, `HVM_OFF_PULL_CFG) ? {30'h0, pull_q} :
        hit(haddr, `HVM_OFF_WAKE_CTRL1) ? {24'h0, wake1_q} :
        hit(haddr, `HVM_OFF_GPIN_CFG) ? {29'h0, gpin_q} :
        hit(haddr, `HVM_OFF_MODE_CMD) ? {29'h0, mode_q} :
        hit(haddr, `HVM_OFF_STATUS) ? {29'h0, fs_wake_q, drive.meas_switch, meas_en_q} :
        hit(haddr, `HVM_OFF_WAKE_STAT0) ? {30'h0, stat0_q} :
        hit(haddr, `HVM_OFF_WAKE_STAT1) ? {31'h0, stat1_q} :
        hit(haddr, `HVM_OFF_WAKE_LVL) ? {30'h0, lvl_q} :
        hit(haddr, `HVM_OFF_ERR) ? {31'h0, err_q} : 32'h0;

    // Pin drive computed combinationally, registered below
    wire logic meas_in_normal = meas_en_q && (mode_q == HVM_NORMAL);
    wire logic fo_active = !meas_en_q && (gpin_q == `HVM_GPIN_FO);
    wire logic fo_level = fo_active && (mode_q == HVM_FAILSAFE || wake1_q[`HVM_BIT_FO_TEST]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            rdata_q <= 32'h0;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr;
            rdata_q <= rd_take ? rsel : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_en_q <= 1'b0;
            pull_q <= `HVM_RST_PULL;
            wake1_q <= `HVM_RST_WAKE1;
            gpin_q <= `HVM_RST_GPIN;
            mode_q <= HVM_INIT;
            err_q <= 1'b0;
        end else begin
            meas_en_q <= meas_d;
            // Writes land even while measuring; pulls and the fail drive stay off until the enable clears
            if (wr_pull) pull_q <= hwdata[1:0];
            if (wr_wake1) wake1_q <= hwdata[7:0];
            if (wr_gpin) gpin_q <= hwdata[2:0];
            mode_q <= mode_d;
            err_q <= err_set | (err_q & ~(wr_err & hwdata[0]));
        end
    end

    // Status capture; a new event wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_prev_q <= '0;
            stat0_q <= 2'h0;
            stat1_q <= 1'b0;
            lvl_q <= 2'h0;
            fs_wake_q <= 1'b0;
        end else begin
            pins_prev_q <= pins_s;
            stat0_q <= {gpin_hit, wake_hit} | (stat0_q & ~({2{wr_stat0}} & hwdata[1:0]));
            stat1_q <= gpin_edge | (stat1_q & ~(wr_stat1 & hwdata[0]));
            if (!meas_en_q) lvl_q <= {gpin_live, wake_live};
            if (mode_d == HVM_FAILSAFE && mode_q != HVM_FAILSAFE) begin
                fs_wake_q <= !meas_en_q;
            end else if (mode_d == HVM_NORMAL) begin
                fs_wake_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive <= '0;
            wake_event <= 1'b0;
            fail_out <= 1'b0;
        end else begin
            drive.meas_switch <= meas_in_normal;
            drive.wake_pull <= meas_en_q ? 2'h0 : pull_q;
            drive.gpin_pull <= meas_en_q ? 2'h0 : pull_q;
            drive.gpin_oe <= fo_active;
            drive.gpin_out <= fo_level;
            wake_event <= wake_hit || gpin_hit;
            fail_out <= fo_level;
        end
    end

    assign mode = mode_q;
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    property p_switch_normal_only;
        @(posedge hclk) disable iff (!hresetn)
        drive.meas_switch |-> $past(meas_en_q) && $past(mode_q) == HVM_NORMAL;
    endproperty
    a_switch_normal_only: assert property (p_switch_normal_only)
        else $error("switch closed outside Normal with enable");

    property p_switch_closes;
        @(posedge hclk) disable iff (!hresetn)
        (meas_en_q && mode_q == HVM_NORMAL) |=> drive.meas_switch;
    endproperty
    a_switch_closes: assert property (p_switch_closes)
        else $error("switch failed to close");

    property p_pulls_off;
        @(posedge hclk) disable iff (!hresetn)
        meas_en_q |=> drive.wake_pull == 2'h0 && drive.gpin_pull == 2'h0;
    endproperty
    a_pulls_off: assert property (p_pulls_off)
        else $error("pull current on while measuring");

    property p_no_events;
        @(posedge hclk) disable iff (!hresetn)
        meas_en_q |=> !wake_event;
    endproperty
    a_no_events: assert property (p_no_events)
        else $error("wake event while measuring");

    property p_status_frozen;
        @(posedge hclk) disable iff (!hresetn)
        (meas_en_q && !wr_stat0) |=> stat0_q == $past(stat0_q) && lvl_q == $past(lvl_q);
    endproperty
    a_status_frozen: assert property (p_status_frozen)
        else $error("status updated while measuring");

    property p_sleep_reject;
        @(posedge hclk) disable iff (!hresetn)
        sleep_reject |=> mode_q == HVM_RESTART && err_q;
    endproperty
    a_sleep_reject: assert property (p_sleep_reject)
        else $error("sleep not rejected while measuring");

    property p_no_fail_drive;
        @(posedge hclk) disable iff (!hresetn)
        meas_en_q |=> !drive.gpin_oe && !fail_out;
    endproperty
    a_no_fail_drive: assert property (p_no_fail_drive)
        else $error("fail output driven while measuring");

    property p_gpin_change_err;
        @(posedge hclk) disable iff (!hresetn)
        gpin_change |=> err_q;
    endproperty
    a_gpin_change_err: assert property (p_gpin_change_err)
        else $error("general pin change not flagged");

    property p_refuse;
        @(posedge hclk) disable iff (!hresetn)
        meas_refuse |=> !meas_en_q && err_q;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("enable accepted with pin not off");

    property p_failsafe_keep;
        @(posedge hclk) disable iff (!hresetn)
        (meas_en_q && mode_q == HVM_FAILSAFE && !wr_meas) |=> meas_en_q && !drive.meas_switch;
    endproperty
    a_failsafe_keep: assert property (p_failsafe_keep)
        else $error("fail-safe lost enable or closed switch");
endmodule

// ### bench/hvm_adc_model.sv
// Far side of the measurement path: a battery source on the wake input and
// a divider into the A/D input on the general pin. Assumes the drive struct.
`timescale 1ns/10ps
module hvm_adc_model (
    input wire hvm_pkg::hvm_drive_t drive,
    input wire logic hv_level,
    output hvm_pkg::hvm_pins_t pins,
    output logic adc_level
);
    import hvm_pkg::*;
    // Divider pulls the pin low when neither the switch nor the driver holds it
    assign adc_level = drive.meas_switch ? hv_level : (drive.gpin_oe & drive.gpin_out);
    // One driver for the whole struct: wake_in first, gpin_in second
    assign pins = {hv_level, adc_level};
endmodule

// ### bench/hv_measurement_switch_ctrl_test.sv
// Self-checking bench for the measurement switch control block.
// Assumes a zero-wait AHB-Lite slave and the register map of the hand-over.
`timescale 1ns/10ps
module hv_measurement_switch_ctrl_test;
    import hvm_pkg::*;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} hvm_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic hv_level = 1'b0;
    logic adc_level;
    hvm_pins_t pins;
    hvm_drive_t drive;
    hvm_mode_t mode;
    logic wake_event;
    logic fail_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_evt = 0;
    logic [31:0] rd;
    hvm_row_t rows [26];

    always #25 hclk = ~hclk;
    always @(posedge hclk) if (wake_event === 1'b1) n_evt++;

    hvm_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins(pins), .drive(drive), .mode(mode), .wake_event(wake_event),
        .fail_out(fail_out));
    hvm_adc_model model_u (.drive(drive), .hv_level(hv_level), .pins(pins),
        .adc_level(adc_level));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task toggle_hv(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            hv_level <= ~hv_level;
            repeat (5) @(posedge hclk);
        end
    endtask

    task test_done;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        n_mismatch++;
        test_done();
    end

    initial begin
        rows = '{
            '{1'b0, 12'h000, 32'h0}, '{1'b0, 12'h00c, 32'h1},   // Off after reset
            '{1'b1, 12'h000, 32'h1}, '{1'b0, 12'h000, 32'h0},   // Refused while pin not off
            '{1'b0, 12'h024, 32'h1}, '{1'b1, 12'h024, 32'h1},
            '{1'b1, 12'h00c, 32'h0}, '{1'b1, 12'h000, 32'h1},
            '{1'b0, 12'h014, 32'h3}, '{1'b1, 12'h004, 32'h3},   // Closed in Normal
            '{1'b0, 12'h004, 32'h3}, '{1'b1, 12'h00c, 32'h2},   // Writes still land
            '{1'b0, 12'h024, 32'h1}, '{1'b1, 12'h024, 32'h1},   // Pin change flagged
            '{1'b1, 12'h008, 32'h10}, '{1'b0, 12'h008, 32'h10},
            '{1'b1, 12'h010, 32'h2}, '{1'b0, 12'h024, 32'h1},   // Sleep refused
            '{1'b0, 12'h010, 32'h1}, '{1'b1, 12'h024, 32'h1},   // Restart back to Normal
            '{1'b1, 12'h010, 32'h3}, '{1'b0, 12'h014, 32'h1},   // Stop opens, keeps enable
            '{1'b1, 12'h010, 32'h7}, '{1'b0, 12'h014, 32'h1},   // Fail-Safe opens
            '{1'b1, 12'h010, 32'h1}, '{1'b0, 12'h030, 32'h0}};  // Unmapped reads zero
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        check({25'h0, drive}, 32'h0);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].d);
        end
        $display("Register table test done");
        repeat (2) @(posedge hclk);
        check({30'h0, drive.wake_pull}, 32'h0);
        check({30'h0, drive.gpin_pull}, 32'h0);
        bus(1'b1, 12'h008, 32'h11);
        // Fail output selected while measuring: must still stay undriven
        bus(1'b1, 12'h00c, 32'h1);
        toggle_hv(3);
        check(n_evt, 32'h0);
        check({31'h0, fail_out | drive.gpin_oe}, 32'h0);
        check({31'h0, adc_level}, {31'h0, hv_level});
        bus(1'b0, 12'h018, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 12'h020, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 12'h01c, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 12'h024, 32'h0);
        check(rd, 32'h1);
        $display("Gating test done");
        bus(1'b1, 12'h000, 32'h0);
        bus(1'b0, 12'h014, 32'h0);
        check(rd, 32'h0);
        toggle_hv(2);
        bus(1'b0, 12'h018, 32'h0);
        check(rd & 32'h1, 32'h1);
        check({31'h0, n_evt != 0}, 32'h1);
        bus(1'b1, 12'h010, 32'h7);
        bus(1'b0, 12'h014, 32'h0);
        check(rd & 32'h7, 32'h4);
        check({31'h0, fail_out}, 32'h1);
        $display("Release test done");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        check({29'h0, mode}, 32'h0);
        check({25'h0, drive}, 32'h0);
        hresetn <= 1'b1;
        bus(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        $display("Reset test done");
        test_done();
    end
endmodule
